// File: common/mmsp_defines.svh
`ifndef MMSP_DEFINES_SVH
`define MMSP_DEFINES_SVH
// ----------------------------------------
// direct addresses of registers held here, and the page that holds PGCN
// ----------------------------------------
`define MMSP_SFR_SP      8'h81
`define MMSP_SFR_PAGE    8'h84
`define MMSP_SFR_NEXT    8'h85
`define MMSP_SFR_LAST    8'h86
`define MMSP_SFR_PGCN    8'h96
`define MMSP_SFR_BANK    8'hB1
`define MMSP_PGCN_PAGE   8'h0F
// ----------------------------------------
// reset values
// ----------------------------------------
`define MMSP_BANK_RST    8'h11
`define MMSP_SP_RST      8'h07
`define MMSP_PGCN_RST    8'h01
`define MMSP_STACK_RST   8'h00
// ----------------------------------------
// field positions and address landmarks
// ----------------------------------------
`define MMSP_CONSTANT_BANK_FIELD_LSB  4
`define MMSP_FETCH_BANK_FIELD_LSB  0
`define MMSP_BANK_MASK   8'h33
`define MMSP_PSW_RS0     3
`define MMSP_PSW_RS1     4
`define MMSP_BITRAM_BASE 8'h20
`define MMSP_REC_W       32
`endif

// File: common/mmsp_pkg.sv
`default_nettype none
package mmsp_pkg;
	// where a data access lands
	typedef enum logic [1:0]
	{
		MMSP_TGT_NONE,
		MMSP_TGT_RAM_LOW,
		MMSP_TGT_RAM_HIGH,
		MMSP_TGT_SFR
	} mmsp_target_t;
endpackage
`default_nettype wire

// File: verilog/mmsp_page_stack.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmsp_defines.svh"
module mmsp_page_stack
(
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	input  wire logic       auto_en_i,
	input  wire logic       irq_enter_i,
	input  wire logic [7:0] irq_page_i,
	input  wire logic       reti_i,
	input  wire logic       wr_page_i,
	input  wire logic       wr_next_i,
	input  wire logic       wr_last_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] page_o,
	output logic      [7:0] next_o,
	output logic      [7:0] last_o
);
	logic [7:0] page_q;
	logic [7:0] next_q;
	logic [7:0] last_q;
	wire        push_w = auto_en_i & irq_enter_i;
	wire        pop_w  = auto_en_i & reti_i & ~irq_enter_i;

	// ----------------------------------------
	// three-byte stack
	// ----------------------------------------
	// a hardware push or pop beats a software write in the same cycle
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			page_q <= `MMSP_STACK_RST;
			next_q <= `MMSP_STACK_RST;
			last_q <= `MMSP_STACK_RST;
		end
		else if (push_w)
		begin
			last_q <= next_q;     // RL18
			next_q <= page_q;     // RL18
			page_q <= irq_page_i; // RL27
		end
		else if (pop_w)
		begin
			page_q <= next_q;            // RL19 RL21
			next_q <= last_q;            // RL19 RL21
			last_q <= `MMSP_STACK_RST;   // RL19
		end
		else
		begin
			if (wr_page_i)
				page_q <= wdata_i; // RL20 RL25
			if (wr_next_i)
				next_q <= wdata_i; // RL20 RL26
			if (wr_last_i)
				last_q <= wdata_i; // RL20
		end
	end

	assign page_o = page_q;
	assign next_o = next_q;
	assign last_o = last_q;
endmodule
`default_nettype wire

// File: verilog/mmsp_stack_record.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmsp_defines.svh"
module mmsp_stack_record
#(
	parameter int REC_W = `MMSP_REC_W
)
(
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic             push1_i,
	input  wire logic             push2_i,
	input  wire logic             pop1_i,
	input  wire logic             pop2_i,
	output logic      [REC_W-1:0] record_o,
	output logic                  overflow_o,
	output logic                  underflow_o
);
	localparam int DW = $clog2(REC_W + 1);
	localparam logic [DW-1:0] FULL = DW'(REC_W);

	if (REC_W < 4)
		$error("stack record too short");

	logic [REC_W-1:0] rec_q;
	logic [DW-1:0]    depth_q;
	logic             ovf_q;
	logic             unf_q;

	// a call marks its pair with 10, a plain push with 0
	wire [1:0] amount_w = push2_i | pop2_i ? 2'h2 : 2'h1;
	wire       grow_w   = push1_i | push2_i;
	wire       shrink_w = pop1_i | pop2_i;
	wire [DW:0] sum_w   = {1'b0, depth_q} + {{(DW-1){1'b0}}, amount_w};
	wire        ovf_w   = grow_w & (sum_w > {1'b0, FULL});
	wire        unf_w   = shrink_w & ~grow_w & (depth_q < {{(DW-2){1'b0}}, amount_w});

	// ----------------------------------------
	// shift register and depth
	// ----------------------------------------
	// depth saturates so a run-away stack keeps reporting instead of wrapping
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rec_q   <= '0;
			depth_q <= '0;
			ovf_q   <= 1'b0;
			unf_q   <= 1'b0;
		end
		else
		begin
			ovf_q <= ovf_w; // RL13
			unf_q <= unf_w; // RL13
			if (push2_i)
			begin
				rec_q   <= {rec_q[REC_W-3:0], 2'h2};                 // RL12
				depth_q <= ovf_w ? FULL : sum_w[DW-1:0];
			end
			else if (push1_i)
			begin
				rec_q   <= {rec_q[REC_W-2:0], 1'b0};                 // RL12
				depth_q <= ovf_w ? FULL : sum_w[DW-1:0];
			end
			else if (pop2_i)
			begin
				rec_q   <= {2'h0, rec_q[REC_W-1:2]};                 // RL12
				depth_q <= unf_w ? '0 : depth_q - DW'(2);
			end
			else if (pop1_i)
			begin
				rec_q   <= {1'b0, rec_q[REC_W-1:1]};                 // RL12
				depth_q <= unf_w ? '0 : depth_q - DW'(1);
			end
		end
	end

	assign record_o    = rec_q;
	assign overflow_o  = ovf_q;
	assign underflow_o = unf_q;
endmodule
`default_nettype wire

// File: verilog/mmsp_top.sv
// How it works
// RL1: constant bank field picks flash bank for upper-window constant accesses
// RL2: constant bank field ignored for scratchpad constant accesses
// RL3: fetch bank field maps upper fetches; lower fetches always bank zero
// RL4: fetch bank field changes only when writer ran from lower bank
// RL5: on small parts software keeps both bank fields at 01
// RL6: above 0x7F, direct goes to registers, indirect to upper RAM
// RL7: lowest 32 bytes are four register banks chosen by status bits
// RL8: indirect pointer comes from working register zero or one of active bank
// RL9: bytes 0x20 to 0x2F give 128 bits, eight per byte
// RL10: stack pointer at 0x81; push writes pointer plus one then increments
// RL11: reset loads stack pointer with 0x07
// RL12: 32-bit record shifts one bit per push/pop, two per call/return
// RL13: record overflow and underflow flagged to debug at full speed
// RL14: registers with low nibble 0 or 8 allow bit access too
// RL15: software avoids unoccupied register addresses
// RL16: eight-bit page select chooses which register page direct accesses reach
// RL17: software sets the page first, then accesses the register
// RL18: interrupt entry pushes page stack and loads the source page
// RL19: return pops the stack; third byte becomes 0x00
// RL20: software writes to stack bytes never push or pop
// RL21: values software placed in stack bytes are restored on return
// RL22: auto paging enable bit resets to enabled
// RL23: certain registers, ports included, decode on every page
// RL24: with auto paging off, interrupt entry keeps the current page
// RL25: page select at 0x84 on all pages, read returns page in use
// RL26: second stack byte at 0x85 on all pages, resets to zero
// RL27: each interrupt source has a fixed page from an integration table
`timescale 1ns/1ps
`default_nettype none
`include "mmsp_defines.svh"
module mmsp_top
	import mmsp_pkg::*;
#(
	parameter int             NUM_IRQ         = 32,
	parameter logic [255:0]   IRQ_PAGE_TABLE  = '0
)
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	// instruction fetch and constant access
	input  wire logic [15:0] fetch_addr_i,
	input  wire logic [15:0] const_addr_i,
	input  wire logic        const_scratch_i,
	input  wire logic [15:0] exec_pc_i,
	// data access from the execute stage
	input  wire logic        acc_valid_i,
	input  wire logic        acc_indirect_i,
	input  wire logic        acc_bit_i,
	input  wire logic        acc_write_i,
	input  wire logic        acc_ri_sel_i,
	input  wire logic [7:0]  acc_addr_i,
	input  wire logic [7:0]  acc_wdata_i,
	input  wire logic [7:0]  psw_i,
	// stack events
	input  wire logic        sp_inc_i,
	input  wire logic        sp_dec_i,
	input  wire logic        call_i,
	input  wire logic        ret_i,
	// interrupt events
	input  wire logic        irq_enter_i,
	input  wire logic [4:0]  irq_src_i,
	input  wire logic        reti_i,
	// registered results
	output logic      [16:0] fetch_flash_addr_o,
	output logic      [16:0] const_flash_addr_o,
	output logic             const_scratch_o,
	output logic      [1:0]  acc_target_o,
	output logic      [7:0]  ram_addr_o,
	output logic      [7:0]  ri_addr_o,
	output logic      [7:0]  sfr_addr_o,
	output logic      [7:0]  sfr_page_o,
	output logic             sfr_all_pages_o,
	output logic             bit_op_o,
	output logic      [2:0]  bit_pos_o,
	output logic             local_hit_o,
	output logic      [7:0]  local_rdata_o,
	output logic      [7:0]  stack_ptr_o,
	output logic      [7:0]  push_addr_o,
	output logic      [31:0] stack_record_o,
	output logic             record_overflow_o,
	output logic             record_underflow_o
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (NUM_IRQ < 1 || NUM_IRQ > 32)
		$error("NUM_IRQ must be 1 to 32");

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// upper window goes to the selected bank, lower window always to bank zero
	function automatic logic [16:0] flash_map(input logic [15:0] addr, input logic [1:0] bank);
		flash_map = addr[15] ? {bank, addr[14:0]} : {2'h0, addr[14:0]};
	endfunction

	// register reachable regardless of the current page
	function automatic logic all_page_reg(input logic [7:0] addr);
		all_page_reg = (addr[3:0] == 4'h0 && addr[7:6] == 2'h2)
			|| addr[7:4] == 4'hB && addr[3:0] == 4'h0
			|| addr == `MMSP_SFR_SP || addr == `MMSP_SFR_PAGE
			|| addr == `MMSP_SFR_NEXT || addr == `MMSP_SFR_LAST
			|| addr == `MMSP_SFR_BANK || addr == 8'hD0 || addr == 8'hE0;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [1:0]  constant_bank_field_q;
	logic [1:0]  fetch_bank_field_q;
	logic        auto_en_q;
	logic [7:0]  sp_q;
	logic [7:0]  push_addr_q;
	logic [16:0] fetch_map_q;
	logic [16:0] const_map_q;
	logic        const_scr_q;
	mmsp_target_t target_q;
	logic [7:0]  ram_addr_q;
	logic [7:0]  ri_addr_q;
	logic [7:0]  sfr_addr_q;
	logic [7:0]  sfr_page_q;
	logic        all_pages_q;
	logic        bit_op_q;
	logic [2:0]  bit_pos_q;
	logic        hit_q;
	logic [7:0]  rdata_q;
	logic [7:0]  page_w;
	logic [7:0]  next_w;
	logic [7:0]  last_w;
	logic [31:0] record_w;
	logic        ovf_w;
	logic        unf_w;

	// ----------------------------------------
	// data address decode
	// ----------------------------------------
	wire        direct_hi_w = ~acc_indirect_i & acc_addr_i[7];
	// bit address splits into byte and position
	wire [7:0]  bit_byte_w  = acc_addr_i[7] ? {acc_addr_i[7:3], 3'h0}           // RL14
		: `MMSP_BITRAM_BASE + {4'h0, acc_addr_i[6:3]};                          // RL9
	wire [7:0]  byte_addr_w = acc_bit_i ? bit_byte_w : acc_addr_i;
	wire        to_sfr_w    = acc_bit_i ? acc_addr_i[7] : direct_hi_w;          // RL6
	wire        is_page_f_w = page_w == `MMSP_PGCN_PAGE;
	wire        common_w    = all_page_reg(byte_addr_w);                        // RL23
	mmsp_target_t target_w;
	assign target_w = ~acc_valid_i ? MMSP_TGT_NONE
		: to_sfr_w ? MMSP_TGT_SFR
		: byte_addr_w[7] ? MMSP_TGT_RAM_HIGH
		: MMSP_TGT_RAM_LOW;                                                     // RL6
	// active bank base plus zero or one
	wire [1:0]  bank_sel_w  = {psw_i[`MMSP_PSW_RS1], psw_i[`MMSP_PSW_RS0]};     // RL7
	wire [7:0]  ri_w        = {3'h0, bank_sel_w, 2'h0, acc_ri_sel_i};           // RL8

	// ----------------------------------------
	// local register strobes
	// ----------------------------------------
	// byte writes only; bit writes to these arrive as read-modify-write bytes
	wire        sfr_wr_w    = acc_valid_i & acc_write_i & to_sfr_w & ~acc_bit_i;
	wire        wr_sp_w     = sfr_wr_w & acc_addr_i == `MMSP_SFR_SP;            // RL10
	wire        wr_page_w   = sfr_wr_w & acc_addr_i == `MMSP_SFR_PAGE;          // RL25
	wire        wr_next_w   = sfr_wr_w & acc_addr_i == `MMSP_SFR_NEXT;          // RL26
	wire        wr_last_w   = sfr_wr_w & acc_addr_i == `MMSP_SFR_LAST;
	wire        wr_bank_w   = sfr_wr_w & acc_addr_i == `MMSP_SFR_BANK;
	wire        wr_pgcn_w   = sfr_wr_w & acc_addr_i == `MMSP_SFR_PGCN & is_page_f_w; // RL16
	wire        from_low_w  = ~exec_pc_i[15];                                   // RL4

	// ----------------------------------------
	// local read mux
	// ----------------------------------------
	wire        rd_sfr_w    = acc_valid_i & ~acc_write_i & to_sfr_w;
	wire        rd_pgcn_w   = byte_addr_w == `MMSP_SFR_PGCN & is_page_f_w;
	wire        rd_hit_w    = rd_sfr_w & (byte_addr_w == `MMSP_SFR_SP
		| byte_addr_w == `MMSP_SFR_PAGE | byte_addr_w == `MMSP_SFR_NEXT
		| byte_addr_w == `MMSP_SFR_LAST | byte_addr_w == `MMSP_SFR_BANK | rd_pgcn_w);
	wire [7:0]  rd_data_w   =
		byte_addr_w == `MMSP_SFR_SP   ? sp_q :
		byte_addr_w == `MMSP_SFR_PAGE ? page_w :                                 // RL25
		byte_addr_w == `MMSP_SFR_NEXT ? next_w :                                 // RL26
		byte_addr_w == `MMSP_SFR_LAST ? last_w :
		byte_addr_w == `MMSP_SFR_BANK ? {2'h0, constant_bank_field_q, 2'h0, fetch_bank_field_q} :
		rd_pgcn_w                     ? {7'h0, auto_en_q} : 8'h00;

	// ----------------------------------------
	// stack pointer arithmetic
	// ----------------------------------------
	// core events take priority over a software write in the same cycle
	wire [7:0]  sp_d = call_i   ? sp_q + 8'h02
		: ret_i    ? sp_q - 8'h02
		: sp_inc_i ? sp_q + 8'h01                                               // RL10
		: sp_dec_i ? sp_q - 8'h01
		: wr_sp_w  ? acc_wdata_i : sp_q;

	// interrupt source to page, fixed at integration
	wire [7:0]  irq_page_w  = IRQ_PAGE_TABLE[{irq_src_i, 3'h0} +: 8];           // RL27

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			constant_bank_field_q  <= 2'(`MMSP_BANK_RST >> `MMSP_CONSTANT_BANK_FIELD_LSB);
			fetch_bank_field_q  <= 2'(`MMSP_BANK_RST);
			auto_en_q <= 1'(`MMSP_PGCN_RST);                                    // RL22
		end
		else
		begin
			if (wr_bank_w)
				constant_bank_field_q <= acc_wdata_i[`MMSP_CONSTANT_BANK_FIELD_LSB +: 2];                  // RL1
			if (wr_bank_w & from_low_w)
				fetch_bank_field_q <= acc_wdata_i[`MMSP_FETCH_BANK_FIELD_LSB +: 2];                  // RL4
			if (wr_pgcn_w)
				auto_en_q <= acc_wdata_i[0];                                     // RL24
		end
	end

	// ----------------------------------------
	// stack pointer
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sp_q        <= `MMSP_SP_RST;                                         // RL11
			push_addr_q <= `MMSP_SP_RST + 8'h01;                                 // RL11
		end
		else
		begin
			sp_q        <= sp_d;
			push_addr_q <= sp_d + 8'h01;                                         // RL10
		end
	end

	// ----------------------------------------
	// code space mapping
	// ----------------------------------------
	// one cycle of latency buys a flop-driven address into the flash
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fetch_map_q <= '0;
			const_map_q <= '0;
			const_scr_q <= 1'b0;
		end
		else
		begin
			fetch_map_q <= flash_map(fetch_addr_i, fetch_bank_field_q);                    // RL3
			const_map_q <= const_scratch_i ? {1'b0, const_addr_i}                // RL2
				: flash_map(const_addr_i, constant_bank_field_q);                             // RL1
			const_scr_q <= const_scratch_i;                                      // RL2
		end
	end

	// ----------------------------------------
	// data access decode
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			target_q    <= MMSP_TGT_NONE;
			ram_addr_q  <= '0;
			ri_addr_q   <= '0;
			sfr_addr_q  <= '0;
			sfr_page_q  <= '0;
			all_pages_q <= 1'b0;
			bit_op_q    <= 1'b0;
			bit_pos_q   <= '0;
			hit_q       <= 1'b0;
			rdata_q     <= '0;
		end
		else
		begin
			target_q    <= target_w;
			ram_addr_q  <= byte_addr_w;
			ri_addr_q   <= ri_w;                                                 // RL8
			sfr_addr_q  <= byte_addr_w;
			sfr_page_q  <= page_w;                                               // RL16
			all_pages_q <= common_w;                                             // RL23
			bit_op_q    <= acc_valid_i & acc_bit_i;                              // RL14
			bit_pos_q   <= acc_addr_i[2:0];                                      // RL9
			hit_q       <= rd_hit_w;
			rdata_q     <= rd_hit_w ? rd_data_w : 8'h00;
		end
	end

	// ----------------------------------------
	// page stack and stack record
	// ----------------------------------------
	mmsp_page_stack u_page_stack
	(
		.core_clk_i  (core_clk_i),
		.reset_i     (reset_i),
		.auto_en_i   (auto_en_q),
		.irq_enter_i (irq_enter_i),
		.irq_page_i  (irq_page_w),
		.reti_i      (reti_i),
		.wr_page_i   (wr_page_w),
		.wr_next_i   (wr_next_w),
		.wr_last_i   (wr_last_w),
		.wdata_i     (acc_wdata_i),
		.page_o      (page_w),
		.next_o      (next_w),
		.last_o      (last_w)
	);

	mmsp_stack_record #(.REC_W(`MMSP_REC_W)) u_record
	(
		.core_clk_i  (core_clk_i),
		.reset_i     (reset_i),
		.push1_i     (sp_inc_i),
		.push2_i     (call_i),
		.pop1_i      (sp_dec_i),
		.pop2_i      (ret_i),
		.record_o    (record_w),
		.overflow_o  (ovf_w),
		.underflow_o (unf_w)
	);

	// ----------------------------------------
	// outputs, all from flops
	// ----------------------------------------
	assign fetch_flash_addr_o = fetch_map_q;
	assign const_flash_addr_o = const_map_q;
	assign const_scratch_o    = const_scr_q;
	assign acc_target_o       = target_q;
	assign ram_addr_o         = ram_addr_q;
	assign ri_addr_o          = ri_addr_q;
	assign sfr_addr_o         = sfr_addr_q;
	assign sfr_page_o         = sfr_page_q;
	assign sfr_all_pages_o    = all_pages_q;
	assign bit_op_o           = bit_op_q;
	assign bit_pos_o          = bit_pos_q;
	assign local_hit_o        = hit_q;
	assign local_rdata_o      = rdata_q;
	assign stack_ptr_o        = sp_q;
	assign push_addr_o        = push_addr_q;
	assign stack_record_o     = record_w;                                        // RL12
	assign record_overflow_o  = ovf_w;                                           // RL13
	assign record_underflow_o = unf_w;                                           // RL13
endmodule
`default_nettype wire

// File: dv/mmsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mmsp_assertions
(
	input wire logic        core_clk_i,
	input wire logic        reset_i,
	input wire logic [15:0] fetch_addr_i,
	input wire logic [15:0] const_addr_i,
	input wire logic        const_scratch_i,
	input wire logic        acc_valid_i,
	input wire logic        acc_indirect_i,
	input wire logic        acc_bit_i,
	input wire logic        acc_ri_sel_i,
	input wire logic [7:0]  acc_addr_i,
	input wire logic [7:0]  psw_i,
	input wire logic        sp_inc_i,
	input wire logic        sp_dec_i,
	input wire logic        call_i,
	input wire logic [16:0] fetch_flash_addr_o,
	input wire logic [16:0] const_flash_addr_o,
	input wire logic [1:0]  acc_target_o,
	input wire logic [7:0]  ram_addr_o,
	input wire logic [7:0]  ri_addr_o,
	input wire logic [7:0]  sfr_addr_o,
	input wire logic [2:0]  bit_pos_o,
	input wire logic [7:0]  stack_ptr_o,
	input wire logic [7:0]  push_addr_o,
	input wire logic [31:0] stack_record_o,
	input wire logic        record_overflow_o,
	input wire logic        record_underflow_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// ----
	// stack
	// ----
	a_sp_reset_value: assert property ($fell(reset_i) |-> stack_ptr_o == 8'h07 && push_addr_o == 8'h08)
		else $error("stack pointer not at reset value");
	a_push_addr_link: assert property (push_addr_o == stack_ptr_o + 8'h01)
		else $error("push address not pointer plus one");
	a_sp_inc_step: assert property (sp_inc_i |=> stack_ptr_o == $past(stack_ptr_o) + 8'h01)
		else $error("pointer did not step on push");
	// a call shifts the record even when it saturates, so the flag term never excuses a missed shift
	a_call_two_bits: assert property (call_i |=> record_overflow_o || stack_record_o == {$past(stack_record_o[29:0]), 2'b10})
		else $error("call did not shift two record bits");
	a_pop_one_bit: assert property (sp_dec_i |=> record_underflow_o || stack_record_o[30:0] == $past(stack_record_o[31:1]))
		else $error("pop did not shift one record bit");
	// ----
	// code and data mapping
	// ----
	a_lower_fetch: assert property (!fetch_addr_i[15] |=> fetch_flash_addr_o == {2'b00, $past(fetch_addr_i[14:0])})
		else $error("lower fetch left bank zero");
	a_scratch_bypass: assert property (const_scratch_i |=> const_flash_addr_o == {1'b0, $past(const_addr_i)})
		else $error("scratchpad access was banked");
	a_direct_to_sfr: assert property (acc_valid_i && !acc_indirect_i && !acc_bit_i && acc_addr_i[7] |=>
		acc_target_o == 2'd3 && sfr_addr_o == $past(acc_addr_i)) else $error("direct upper access missed registers");
	a_indirect_upper: assert property (acc_valid_i && acc_indirect_i && acc_addr_i[7] |=>
		acc_target_o == 2'd2 && ram_addr_o == $past(acc_addr_i)) else $error("indirect upper access missed RAM");
	a_bit_ram_map: assert property (acc_valid_i && acc_bit_i && !acc_addr_i[7] |=>
		ram_addr_o == {4'h2, $past(acc_addr_i[6:3])} && bit_pos_o == $past(acc_addr_i[2:0])) else $error("bit RAM map");
	a_bit_sfr_map: assert property (acc_valid_i && acc_bit_i && acc_addr_i[7] |=>
		sfr_addr_o == {$past(acc_addr_i[7:3]), 3'b000}) else $error("bit register map");
	a_ri_bank: assert property (acc_valid_i |=> ri_addr_o == {3'b000, $past(psw_i[4:3]), 2'b00, $past(acc_ri_sel_i)})
		else $error("index register outside active bank");
endmodule
`default_nettype wire

// File: dv/mmsp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmsp_core_model
(
	input  wire logic       core_clk_i,
	input  wire logic       reset_i,
	input  wire logic [1:0] mode_i,
	output logic            sp_inc_o,
	output logic            sp_dec_o,
	output logic            call_o,
	output logic            ret_o
);
	logic [2:0] pick;
	// at most one stack event a cycle; mode 1 random, 2 calls, 3 returns
	always @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			pick = 3'd0;
		else if (mode_i == 2'd1)
			pick = 3'($urandom_range(4, 0));
		else
			pick = (mode_i == 2'd2) ? 3'd3 : (mode_i == 2'd3) ? 3'd4 : 3'd0;
		sp_inc_o <= (pick == 3'd1);
		sp_dec_o <= (pick == 3'd2);
		call_o   <= (pick == 3'd3);
		ret_o    <= (pick == 3'd4);
	end
endmodule
`default_nettype wire

// File: dv/mmsp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmsp_defines.svh"
module mmsp_top_test;
	localparam logic [255:0] TBL = {8{32'h0F03_0201}};
	logic        core_clk_i, reset_i, const_scratch_i, acc_valid_i, acc_indirect_i, acc_bit_i;
	logic        acc_write_i, acc_ri_sel_i, irq_enter_i, reti_i, sp_inc_i, sp_dec_i, call_i;
	logic        ret_i, const_scratch_o, sfr_all_pages_o, bit_op_o, local_hit_o;
	logic        record_overflow_o, record_underflow_o;
	logic [1:0]  acc_target_o, mode;
	logic [2:0]  bit_pos_o;
	logic [4:0]  irq_src_i;
	logic [7:0]  acc_addr_i, acc_wdata_i, psw_i, ram_addr_o, ri_addr_o, sfr_addr_o, sfr_page_o;
	logic [7:0]  local_rdata_o, stack_ptr_o, push_addr_o, esp;
	logic [15:0] fetch_addr_i, const_addr_i, exec_pc_i;
	logic [16:0] fetch_flash_addr_o, const_flash_addr_o;
	logic [31:0] stack_record_o, r;
	int          mismatches, checks, ovf, unf;

	mmsp_top #(.IRQ_PAGE_TABLE(TBL)) dut (.*);
	mmsp_core_model u_core (.core_clk_i, .reset_i, .mode_i(mode), .sp_inc_o(sp_inc_i),
		.sp_dec_o(sp_dec_i), .call_o(call_i), .ret_o(ret_i));

	initial
	begin
		core_clk_i = 0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// expected pointer from the core's events, and counts of the record overflow and underflow flags
	always @(posedge core_clk_i or posedge reset_i)
		if (reset_i)
			esp <= 8'h07;
		else
			esp <= esp + 8'(call_i * 2 + sp_inc_i) - 8'(ret_i * 2 + sp_dec_i);
	always @(negedge core_clk_i)
	begin
		ovf += record_overflow_o;
		unf += record_underflow_o;
	end
	// ----
	// tasks
	// ----
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic ind, bt, wr, input logic [7:0] a, d);
		@(posedge core_clk_i);
		acc_valid_i    <= 1;
		acc_indirect_i <= ind;
		acc_bit_i      <= bt;
		acc_write_i    <= wr;
		acc_addr_i     <= a;
		acc_wdata_i    <= d;
		@(posedge core_clk_i);
		acc_valid_i <= 0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		acc(0, 0, 0, a, 8'h00);
		cmp(local_rdata_o, exp);
		cmp(local_hit_o, 1'b1);
	endtask
	task automatic irq(input logic ent, input logic [4:0] s);
		@(posedge core_clk_i);
		irq_enter_i <= ent;
		reti_i      <= !ent;
		irq_src_i   <= s;
		@(posedge core_clk_i);
		irq_enter_i <= 0;
		reti_i      <= 0;
	endtask
	function automatic logic [1:0] tgt(input logic ind, bt, hi);
		return (hi & !bt & ind) ? 2'd2 : hi ? 2'd3 : 2'd1;
	endfunction
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		{fetch_addr_i, const_addr_i, exec_pc_i, acc_addr_i, acc_wdata_i, psw_i, irq_src_i, mode} = '0;
		{const_scratch_i, acc_valid_i, acc_indirect_i, acc_bit_i, acc_write_i, acc_ri_sel_i} = '0;
		{irq_enter_i, reti_i} = '0;
		void'($urandom(32'hd19cf33c));
		reset_i = 1;
		repeat (8) @(posedge core_clk_i);
		reset_i <= 0;
		cmp(stack_ptr_o, `MMSP_SP_RST);
		rd(`MMSP_SFR_BANK, `MMSP_BANK_RST);
		rd(`MMSP_SFR_NEXT, 8'h00);
		acc(0, 0, 1, `MMSP_SFR_PAGE, 8'h0F);
		rd(`MMSP_SFR_PGCN, 8'h01);
		exec_pc_i <= 16'h8000;
		acc(0, 0, 1, `MMSP_SFR_BANK, 8'h32);
		rd(`MMSP_SFR_BANK, 8'h31);
		exec_pc_i <= 16'h0000;
		// every bank code for fetch and constant windows
		for (int k = 0; k < 4; k++)
		begin
			acc(0, 0, 1, `MMSP_SFR_BANK, 8'(k * 8'h11));
			@(posedge core_clk_i);
			fetch_addr_i <= 16'h8000 | 16'($urandom);
			const_addr_i <= 16'h8000 | 16'($urandom);
			@(posedge core_clk_i);
			#1;
			cmp(fetch_flash_addr_o, {k[1:0], fetch_addr_i[14:0]});
			cmp(const_flash_addr_o, {k[1:0], const_addr_i[14:0]});
		end
		@(posedge core_clk_i);
		fetch_addr_i    <= 16'h7FFF;
		const_scratch_i <= 1;
		@(posedge core_clk_i);
		#1;
		cmp(fetch_flash_addr_o, 17'h07FFF);
		cmp(const_flash_addr_o, {1'b0, const_addr_i});
		cmp(const_scratch_o, 1'b1);
		// random data accesses while the core pushes and pops at random
		mode <= 2'd1;
		repeat (200)
		begin
			r = $urandom;
			@(posedge core_clk_i);
			psw_i        <= r[15:8];
			acc_ri_sel_i <= r[16];
			acc(r[17], r[18] & ~r[17], 0, r[7:0], 8'h00);
			cmp(ri_addr_o, {3'b000, r[12:11], 2'b00, r[16]});
			cmp(acc_target_o, tgt(r[17], r[18] & ~r[17], r[7]));
		end
		mode <= 2'd0;
		acc(0, 1, 0, 8'h7F, 8'h00);
		cmp(ram_addr_o, 8'h2F);
		cmp(bit_op_o, 1'b1);
		acc(0, 1, 0, 8'hD5, 8'h00);
		cmp(sfr_addr_o, 8'hD0);
		acc(0, 0, 0, 8'h80, 8'h00);
		cmp(sfr_all_pages_o, 1'b1);
		cmp(sfr_page_o, 8'h0F);
		cmp(stack_ptr_o, esp);
		// nested entries, software edit of the stack, returns
		irq(1, 5'd0);
		rd(`MMSP_SFR_PAGE, 8'h01);
		rd(`MMSP_SFR_NEXT, 8'h0F);
		irq(1, 5'd3);
		rd(`MMSP_SFR_LAST, 8'h0F);
		acc(0, 0, 1, `MMSP_SFR_NEXT, 8'h02);
		rd(`MMSP_SFR_PAGE, 8'h0F);
		irq(0, 5'd0);
		rd(`MMSP_SFR_PAGE, 8'h02);
		rd(`MMSP_SFR_LAST, 8'h00);
		irq(0, 5'd0);
		rd(`MMSP_SFR_PAGE, 8'h0F);
		acc(0, 0, 1, `MMSP_SFR_PGCN, 8'h00);
		irq(1, 5'd1);
		rd(`MMSP_SFR_PAGE, 8'h0F);
		// second reset, then fill and drain the record past both ends
		@(posedge core_clk_i);
		reset_i <= 1;
		repeat (2) @(posedge core_clk_i);
		reset_i <= 0;
		ovf = 0;
		unf = 0;
		mode <= 2'd2;
		repeat (17) @(posedge core_clk_i);
		mode <= 2'd3;
		repeat (17) @(posedge core_clk_i);
		mode <= 2'd0;
		repeat (3) @(posedge core_clk_i);
		#1;
		cmp(ovf, 1);
		cmp(unf, 1);
		cmp(stack_ptr_o, 8'h07);
		print_verdict();
	end
	// hang guard, far beyond the fewer than a thousand cycles the tests need
	initial
	begin
		#200us;
		mismatches++;
		print_verdict();
	end
endmodule
bind mmsp_top mmsp_assertions u_chk (.*);
`default_nettype wire
